/* rtl/imbr_consts.vh */
`ifndef IMBR_CONSTS_VH
`define IMBR_CONSTS_VH

// ----------------------------------------------------------------
// register byte addresses (lower byte; upper byte is +1)
// ----------------------------------------------------------------
`define IMBR_ADDR_SUPPLY      7'h02
`define IMBR_ADDR_AUX         7'h16
`define IMBR_ADDR_RATE_X_OFF  7'h1a
`define IMBR_ADDR_RATE_Y_OFF  7'h1c
`define IMBR_ADDR_RATE_Z_OFF  7'h1e
`define IMBR_ADDR_DIAG        7'h3c

// ----------------------------------------------------------------
// frame layout and commands
// ----------------------------------------------------------------
`define IMBR_CMD_BURST        16'h3e00
`define IMBR_FRAME_BITS       5'h10
`define IMBR_WRITE_BIT        15
`define IMBR_ND_BIT           15
`define IMBR_EA_BIT           14
`define IMBR_NUM_OUT          4'hb
`define IMBR_OFF_WIDTH        13
`define IMBR_OFF_RESET        13'h0000

// ----------------------------------------------------------------
// gyro range select codes
// ----------------------------------------------------------------
`define IMBR_RANGE_300        3'h4
`define IMBR_RANGE_150        3'h2
`define IMBR_RANGE_75         3'h1

// ----------------------------------------------------------------
// sample buffer
// ----------------------------------------------------------------
`define IMBR_FIFO_DEPTH       8
`define IMBR_FIFO_AW          3
`define IMBR_SAMPLE_W         150

`endif

/* rtl/imbr_readout.v */
// What this block does
// R1: the master opens a burst by sending the command word 0x3e00 on the data input.
// R2: in a burst every output register leaves as a 16-bit word, one word per 16-clock frame.
// R3: burst words run in address order from supply through every output to the aux converter.
// R4: an output register's new-data flag reads 1 while its value is still unread.
// R5: an output register's error flag is high while any diagnostic status flag is set.
// R6: supply is a 12-bit offset-binary value at 2.418 mV per step.
// R7: each rate output is a 14-bit two's-complement value at 0.05 deg/s per step in the widest range.
// R8: the rate scale follows the selected range, finer steps for narrower ranges.
// R9: each acceleration output is a 14-bit two's-complement value at 1 milli-g per step.
// R10: each temperature output is a 12-bit two's-complement value at 0.136 deg C per step.
// R11: temperature code zero stands for 25 deg C, other codes are signed offsets from it.
// R12: the aux converter output is 12-bit offset binary at 805.8 uV per step, zero at 0 V.
// R13: each rate bias offset is 13-bit two's complement in bits 12..0, bits 15..13 unused.
// R14: the bias offset, in its own step units, is added to the matching rate output.
// R15: the master writes a 16-bit offset as two byte writes, upper and lower byte.
// R16: a single read is a frame with the write flag clear and an address, answered next frame.
// R17: output words hold new-data in bit 15, error in bit 14, data right-justified.
`timescale 1ns/1ps
`include "imbr_consts.vh"

// ----------------------------------------------------------------
// sample buffer
// ----------------------------------------------------------------
module imbr_fifo #(
  parameter WIDTH = `IMBR_SAMPLE_W,
  parameter DEPTH = `IMBR_FIFO_DEPTH,
  parameter AW    = `IMBR_FIFO_AW
) (
  input  wire             clk_sys,
  input  wire             nrst,
  input  wire             in_valid,
  output reg              in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  reg [AW:0]      next_count;
  wire            push;
  wire            pop;
  assign push      = in_valid & in_ready;
  assign out_valid = (count != {(AW+1){1'b0}});
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rd_ptr];
  always @*
  begin
    next_count = count;
    if (push & ~pop)
      next_count = count + 1'b1;
    else if (pop & ~push)
      next_count = count - 1'b1;
  end
  always @(posedge clk_sys)
    if (push)
      mem[wr_ptr] <= in_data;
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_ptr   <= {AW{1'b0}};
      rd_ptr   <= {AW{1'b0}};
      count    <= {(AW+1){1'b0}};
      in_ready <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      count    <= next_count;
      // registered ready: full is known one cycle ahead
      in_ready <= (next_count != DEPTH[AW:0]);
    end
  end
endmodule // imbr_fifo

// ----------------------------------------------------------------
// output register bank and serial slave
// ----------------------------------------------------------------
module imbr_readout (
  input  wire        clk_sys,
  input  wire        nrst,
  input  wire        sclk,
  input  wire        cs_n,
  input  wire        din,
  output reg         dout,
  output reg         dout_en_n,
  input  wire        sample_valid,
  output wire        sample_ready,
  input  wire [11:0] supply_raw,
  input  wire [15:0] rate_x_raw,
  input  wire [15:0] rate_y_raw,
  input  wire [15:0] rate_z_raw,
  input  wire [13:0] accel_x_raw,
  input  wire [13:0] accel_y_raw,
  input  wire [13:0] accel_z_raw,
  input  wire [11:0] temp_x_raw,
  input  wire [11:0] temp_y_raw,
  input  wire [11:0] temp_z_raw,
  input  wire [11:0] aux_raw,
  input  wire [2:0]  range_sel,
  input  wire [15:0] diagnostic_status
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  reg [2:0]  sclk_s;
  reg [1:0]  cs_s;
  reg [1:0]  din_s;
  reg        cs_q;
  wire       sclk_rise;
  wire       sclk_fall;
  wire       cs_act;
  wire       cs_fall;
  assign sclk_rise = sclk_s[1] & ~sclk_s[2];
  assign sclk_fall = ~sclk_s[1] & sclk_s[2];
  assign cs_act    = ~cs_s[1];
  assign cs_fall   = cs_act & cs_q;
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sclk_s <= 3'h7;
      cs_s   <= 2'h3;
      din_s  <= 2'h0;
      cs_q   <= 1'b1;
    end
    else
    begin
      sclk_s <= {sclk_s[1:0], sclk};
      cs_s   <= {cs_s[0], cs_n};
      din_s  <= {din_s[0], din};
      cs_q   <= cs_s[1];
    end
  end

  // ----------------------------------------------------------------
  // sample path
  // ----------------------------------------------------------------
  wire [`IMBR_SAMPLE_W-1:0] in_pack;
  wire [`IMBR_SAMPLE_W-1:0] smp;
  wire                      smp_valid;
  wire                      smp_pop;
  reg                       burst_act;
  assign in_pack = {supply_raw, rate_x_raw, rate_y_raw, rate_z_raw,
                    accel_x_raw, accel_y_raw, accel_z_raw,
                    temp_x_raw, temp_y_raw, temp_z_raw, aux_raw};
  // hold updates while burst_act is set; a pop in the command frame's frame_done cycle leaves word 0 from the older sample set
  assign smp_pop = smp_valid & ~burst_act;
  imbr_fifo #(
    .WIDTH (`IMBR_SAMPLE_W),
    .DEPTH (`IMBR_FIFO_DEPTH),
    .AW    (`IMBR_FIFO_AW)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .in_data   (in_pack),
    .out_valid (smp_valid),
    .out_ready (~burst_act),
    .out_data  (smp)
  );
  // bias offsets, one per rate axis
  reg  [`IMBR_OFF_WIDTH-1:0] bias [0:2];
  wire [13:0]                rate_val [0:2];
  reg  [1:0]                 shamt;
  always @*
    case (range_sel)
      `IMBR_RANGE_150: shamt = 2'h1; // R8
      `IMBR_RANGE_75:  shamt = 2'h0; // R8
      default:         shamt = 2'h2; // R7
    endcase
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_rate
      wire        [15:0] raw;
      wire signed [16:0] sum;
      wire signed [16:0] scl;
      assign raw = smp[137-16*g -: 16];
      // raw and offset share the finest step; range sets the output step
      assign sum = $signed({raw[15], raw}) +
                   $signed({{4{bias[g][12]}}, bias[g]}); // R14
      assign scl = sum >>> shamt; // R8
      assign rate_val[g] = (scl > 17'sh01fff)  ? 14'h1fff :
                           (scl < -17'sh02000) ? 14'h2000 :
                           scl[13:0]; // R7
    end
  endgenerate
  // ----------------------------------------------------------------
  // output registers and flags
  // ----------------------------------------------------------------
  reg  [13:0] out_val [0:10];
  reg  [10:0] nd;
  reg  [10:0] rd_clr;
  wire        ea;
  integer     k;
  assign ea = |diagnostic_status; // R5
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      for (k = 0; k < 11; k = k + 1)
        out_val[k] <= 14'h0000;
    end
    else if (smp_pop)
    begin
      out_val[0]  <= {2'h0, smp[149:138]}; // R6
      out_val[1]  <= rate_val[0];
      out_val[2]  <= rate_val[1];
      out_val[3]  <= rate_val[2];
      out_val[4]  <= smp[89:76]; // R9
      out_val[5]  <= smp[75:62]; // R9
      out_val[6]  <= smp[61:48]; // R9
      out_val[7]  <= {2'h0, smp[47:36]}; // R10 R11
      out_val[8]  <= {2'h0, smp[35:24]}; // R10 R11
      out_val[9]  <= {2'h0, smp[23:12]}; // R10 R11
      out_val[10] <= {2'h0, smp[11:0]}; // R12
    end
  end
  generate
    for (g = 0; g < 11; g = g + 1)
    begin : g_nd
      // a new sample wins over a read in the same cycle
      always @(posedge clk_sys or negedge nrst)
        if (!nrst)
          nd[g] <= 1'b0;
        else if (smp_pop)
          nd[g] <= 1'b1; // R4
        else if (rd_clr[g])
          nd[g] <= 1'b0; // R4
    end
  endgenerate
  function [15:0] out_word;
    input [3:0] idx;
    begin
      out_word = {nd[idx], ea, out_val[idx]}; // R17 R5 R4
    end
  endfunction

  // ----------------------------------------------------------------
  // serial frame engine
  // ----------------------------------------------------------------
  reg  [4:0]  bit_cnt;
  reg  [15:0] rx;
  reg         frame_done;
  reg  [15:0] tx;
  reg  [15:0] pending;
  reg  [3:0]  burst_idx;
  wire [6:0]  addr;
  wire [3:0]  rd_idx;
  wire        rd_is_out;
  assign addr      = rx[14:8];
  assign rd_idx    = addr[4:1] - 4'h1;
  assign rd_is_out = (addr >= `IMBR_ADDR_SUPPLY) && (addr <= (`IMBR_ADDR_AUX + 7'h01));
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      bit_cnt    <= 5'h00;
      rx         <= 16'h0000;
      frame_done <= 1'b0;
    end
    else
    begin
      frame_done <= 1'b0;
      if (!cs_act)
        bit_cnt <= 5'h00;
      else if (sclk_rise)
      begin
        rx <= {rx[14:0], din_s[1]};
        if (bit_cnt == `IMBR_FRAME_BITS - 5'h01)
        begin
          bit_cnt    <= 5'h00;
          frame_done <= 1'b1;
        end
        else
          bit_cnt <= bit_cnt + 5'h01;
      end
    end
  end
  always @*
  begin
    rd_clr = 11'h000;
    if (frame_done)
    begin
      if (burst_act && (burst_idx < `IMBR_NUM_OUT))
        rd_clr[burst_idx] = 1'b1; // R4
      else if (!burst_act && (rx == `IMBR_CMD_BURST))
        rd_clr[0] = 1'b1; // R4
      else if (!burst_act && !rx[`IMBR_WRITE_BIT] && rd_is_out)
        rd_clr[rd_idx] = 1'b1; // R4
    end
  end
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      pending   <= 16'h0000;
      burst_act <= 1'b0;
      burst_idx <= 4'h0;
      bias[0]   <= `IMBR_OFF_RESET;
      bias[1]   <= `IMBR_OFF_RESET;
      bias[2]   <= `IMBR_OFF_RESET;
    end
    else if (!cs_act)
      burst_act <= 1'b0;
    else if (frame_done)
    begin
      if (burst_act)
      begin
        if (burst_idx < `IMBR_NUM_OUT)
        begin
          pending   <= out_word(burst_idx); // R2 R3
          burst_idx <= burst_idx + 4'h1; // R3
        end
        else
        begin
          pending   <= 16'h0000;
          burst_act <= 1'b0;
        end
      end
      else if (rx == `IMBR_CMD_BURST)
      begin
        pending   <= out_word(4'h0); // R1 R3
        burst_idx <= 4'h1;
        burst_act <= 1'b1; // R1
      end
      else if (!rx[`IMBR_WRITE_BIT])
      begin
        // R16
        if (rd_is_out)
          pending <= out_word(rd_idx);
        else if (addr[6:1] == `IMBR_ADDR_RATE_X_OFF >> 1)
          pending <= {3'h0, bias[0]}; // R13
        else if (addr[6:1] == `IMBR_ADDR_RATE_Y_OFF >> 1)
          pending <= {3'h0, bias[1]}; // R13
        else if (addr[6:1] == `IMBR_ADDR_RATE_Z_OFF >> 1)
          pending <= {3'h0, bias[2]}; // R13
        else if (addr[6:1] == `IMBR_ADDR_DIAG >> 1)
          pending <= diagnostic_status;
        else
          pending <= 16'h0000;
      end
      else
      begin
        pending <= 16'h0000;
        // byte writes; upper byte keeps only bits 12..8
        case (addr)
          `IMBR_ADDR_RATE_X_OFF:         bias[0][7:0]  <= rx[7:0]; // R15
          `IMBR_ADDR_RATE_X_OFF + 7'h01: bias[0][12:8] <= rx[4:0]; // R15 R13
          `IMBR_ADDR_RATE_Y_OFF:         bias[1][7:0]  <= rx[7:0]; // R15
          `IMBR_ADDR_RATE_Y_OFF + 7'h01: bias[1][12:8] <= rx[4:0]; // R15 R13
          `IMBR_ADDR_RATE_Z_OFF:         bias[2][7:0]  <= rx[7:0]; // R15
          `IMBR_ADDR_RATE_Z_OFF + 7'h01: bias[2][12:8] <= rx[4:0]; // R15 R13
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // serial output, changes on falling clock, sampled on rising
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      tx        <= 16'h0000;
      dout      <= 1'b0;
      dout_en_n <= 1'b1;
    end
    else if (!cs_act)
    begin
      dout      <= 1'b0;
      dout_en_n <= 1'b1;
    end
    else
    begin
      dout_en_n <= 1'b0;
      if (cs_fall || (sclk_fall && (bit_cnt == 5'h00)))
      begin
        tx   <= pending; // R2
        dout <= pending[15];
      end
      else if (sclk_fall)
      begin
        tx   <= {tx[14:0], 1'b0};
        dout <= tx[14];
      end
    end
  end
endmodule // imbr_readout

/* testbench/imbr_readout_monitor.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// frame tracker
// ----------------------------------------------------------------
module imbr_readout_chk (
  input wire        clk_sys,
  input wire        nrst,
  input wire        sclk,
  input wire        cs_n,
  input wire        din,
  input wire        dout,
  input wire        dout_en_n,
  input wire        sample_valid,
  input wire        sample_ready,
  input wire [15:0] diagnostic_status
);
  reg         sclk_q;
  reg  [3:0]  cnt;
  reg  [14:0] si;
  reg  [14:0] so;
  reg  [3:0]  bl;
  reg         rq;
  reg  [6:0]  ra;
  wire        done = sclk && !sclk_q && !cs_n && cnt == 4'hf;
  wire [15:0] w    = {so, dout};
  wire [15:0] wi   = {si, din};
  wire        ea   = |diagnostic_status;
  wire        sgl  = done && bl == 4'h0 && rq;
  // burst words are counted down so din is not decoded inside them
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sclk_q <= 1'b1;
      cnt    <= 4'h0;
      si     <= 15'h0000;
      so     <= 15'h0000;
      bl     <= 4'h0;
      rq     <= 1'b0;
      ra     <= 7'h00;
    end
    else
    begin
      sclk_q <= sclk;
      if (cs_n)
      begin
        cnt <= 4'h0;
        bl  <= 4'h0;
      end
      else if (sclk && !sclk_q)
      begin
        cnt <= cnt + 4'h1;
        si  <= wi[14:0];
        so  <= w[14:0];
        if (done)
        begin
          rq <= bl == 4'h0 && !wi[15];
          ra <= wi[14:8];
          if (bl != 4'h0)
            bl <= bl - 4'h1;
          else if (wi == 16'h3e00)
            bl <= 4'hb;
        end
      end
    end
  end
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  idle_quiet_a: assert property (cs_n [*6] |-> dout_en_n && !dout)
    else $error("dout not released");
  drive_on_a: assert property (!cs_n [*6] |-> !dout_en_n)
    else $error("dout not driven");
  dout_hold_a: assert property ((sclk && !cs_n) [*6] |-> $stable(dout))
    else $error("dout moved while sclk high");
  full_push_a: assert property ($fell(sample_ready) |-> $past(sample_valid))
    else $error("buffer full without push");
  burst_pad_a: assert property (done && (bl == 4'hb || (bl != 4'h0 && bl < 4'h5))
    |-> w[13:12] == 2'b00) else $error("12-bit word not padded");
  burst_flag_a: assert property (done && bl != 4'h0 |-> w[14] == ea)
    else $error("burst error flag wrong");
  bias_top_a: assert property (sgl && ra >= 7'h1a && ra <= 7'h1f |-> w[15:13] == 3'h0)
    else $error("bias unused bits set");
  diag_read_a: assert property (sgl && ra == 7'h3c |-> w == diagnostic_status)
    else $error("status read wrong");
  read_flag_a: assert property (sgl && ra >= 7'h02 && ra <= 7'h17 |-> w[14] == ea)
    else $error("read error flag wrong");
  cover property (done && bl == 4'hb);
  cover property (sgl && ra == 7'h3c);
  cover property ($fell(sample_ready));
endmodule // imbr_readout_chk

bind imbr_readout imbr_readout_chk u_chk (.clk_sys, .nrst, .sclk, .cs_n, .din, .dout,
  .dout_en_n, .sample_valid, .sample_ready, .diagnostic_status);

/* testbench/imbr_host.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// serial master, clock idles high, msb first
// ----------------------------------------------------------------
module imbr_host (
  input  wire clk_sys,
  input  wire dout,
  output reg  sclk,
  output reg  cs_n,
  output reg  din
);
  initial
  begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din  = 1'b0;
  end
  // call at a falling clk edge; dout taken just before each rise
  task xfer(input [15:0] tx, input last, output [15:0] rx);
    integer i;
    begin
      if (cs_n)
      begin
        cs_n = 1'b0;
        repeat (4) @(negedge clk_sys);
      end
      for (i = 15; i >= 0; i = i - 1)
      begin
        sclk = 1'b0;
        din  = tx[i];
        repeat (4) @(negedge clk_sys);
        rx[i] = dout;
        sclk  = 1'b1;
        repeat (4) @(negedge clk_sys);
      end
      // stale bit inverted so it is never read as data
      din  = ~din;
      cs_n = last;
      repeat (4) @(negedge clk_sys);
    end
  endtask
endmodule // imbr_host

/* testbench/tb_top.sv */
`timescale 1ns/1ps
`include "imbr_consts.vh"
module tb_top;
  reg         clk_sys, nrst, sample_valid;
  wire        sclk, cs_n, din, dout, dout_en_n, sample_ready;
  reg  [11:0] supply_raw, temp_x_raw, temp_y_raw, temp_z_raw, aux_raw;
  reg  [15:0] rate_x_raw, rate_y_raw, rate_z_raw, diagnostic_status, rx;
  reg  [13:0] accel_x_raw, accel_y_raw, accel_z_raw;
  reg  [2:0]  range_sel;
  reg  [15:0] bw [0:10];
  reg  [15:0] ex [0:10];
  reg  [6:0]  a;
  integer     errors, n_compared, cyc, i, k;

  imbr_readout u_dut (.clk_sys, .nrst, .sclk, .cs_n, .din, .dout, .dout_en_n,
    .sample_valid, .sample_ready, .supply_raw, .rate_x_raw, .rate_y_raw, .rate_z_raw,
    .accel_x_raw, .accel_y_raw, .accel_z_raw, .temp_x_raw, .temp_y_raw, .temp_z_raw,
    .aux_raw, .range_sel, .diagnostic_status);
  imbr_host u_host (.clk_sys, .dout, .sclk, .cs_n, .din);

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task complete_run;
    begin
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  task chk(input [95:0] nm, input [15:0] e, input [15:0] g);
    begin
      n_compared = n_compared + 1;
      if (g !== e)
      begin
        $display("unexpected %0s exp %h got %h", nm, e, g);
        errors = errors + 1;
      end
    end
  endtask
  task rdc(input [6:0] ad, input [15:0] e, input [95:0] nm);
    reg [15:0] d;
    begin
      u_host.xfer({1'b0, ad, 8'h00}, 1'b1, rx);
      u_host.xfer(16'h0000, 1'b1, d);
      chk(nm, e, d);
    end
  endtask
  task wr(input [6:0] ad, input [7:0] v);
    u_host.xfer({1'b1, ad, v}, 1'b1, rx);
  endtask
  task burst;
    integer j;
    begin
      u_host.xfer(`IMBR_CMD_BURST, 1'b0, rx);
      for (j = 0; j < 11; j = j + 1)
        u_host.xfer(16'h0000, j == 10, bw[j]);
    end
  endtask
  task push(input [11:0] s);
    integer n;
    begin
      n = 0;
      while (sample_ready !== 1'b1 && n < 50)
      begin
        @(negedge clk_sys);
        n = n + 1;
      end
      supply_raw   = s;
      sample_valid = 1'b1;
      @(negedge clk_sys);
    end
  endtask
  // rate raw steps are a quarter of the widest-range step
  task bcheck(input nd, input ea, input integer sh, input integer bx);
    integer r, j;
    begin
      ex[0]  = {nd, ea, 2'b00, supply_raw};
      r      = ($signed(rate_x_raw) + bx) >>> sh;
      ex[1]  = {nd, ea, r[13:0]};
      r      = $signed(rate_y_raw) >>> sh;
      ex[2]  = {nd, ea, r[13:0]};
      r      = $signed(rate_z_raw) >>> sh;
      ex[3]  = {nd, ea, r[13:0]};
      ex[4]  = {nd, ea, accel_x_raw};
      ex[5]  = {nd, ea, accel_y_raw};
      ex[6]  = {nd, ea, accel_z_raw};
      ex[7]  = {nd, ea, 2'b00, temp_x_raw};
      ex[8]  = {nd, ea, 2'b00, temp_y_raw};
      ex[9]  = {nd, ea, 2'b00, temp_z_raw};
      ex[10] = {nd, ea, 2'b00, aux_raw};
      for (j = 0; j < 11; j = j + 1)
        chk("burst word", ex[j], bw[j]);
    end
  endtask

  always @(posedge clk_sys)
  begin
    cyc = cyc + 1;
    if (cyc == 40000)
    begin
      errors = errors + 1;
      complete_run;
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    errors = 0;
    n_compared = 0;
    cyc = 0;
    nrst = 1'b0;
    sample_valid = 1'b0;
    range_sel = 3'h4;
    diagnostic_status = 16'h0000;
    supply_raw = 12'h814;
    rate_x_raw = 16'h0028;
    rate_y_raw = 16'h0028;
    rate_z_raw = 16'hfffc;
    accel_x_raw = 14'h1388;
    accel_y_raw = 14'h3fff;
    accel_z_raw = 14'h2c78;
    temp_x_raw = 12'h000;
    temp_y_raw = 12'hfff;
    temp_z_raw = 12'h24c;
    aux_raw = 12'hfff;
    repeat (4) @(negedge clk_sys);
    chk("ready rst", 16'h0000, {15'h0000, sample_ready});
    nrst = 1'b1;
    repeat (4) @(negedge clk_sys);
    for (a = 7'h1a; a < 7'h20; a = a + 7'h02)
      rdc(a, 16'h0000, "bias reset");
    push(12'h814);
    sample_valid = 1'b0;
    repeat (8) @(negedge clk_sys);
    burst;
    bcheck(1'b1, 1'b0, 2, 0);
    burst;
    bcheck(1'b0, 1'b0, 2, 0);
    diagnostic_status = 16'h0001;
    rdc(7'h0a, 16'h5388, "accel x ea");
    rdc(7'h3c, 16'h0001, "status");
    diagnostic_status = 16'h0000;
    wr(7'h1b, 8'hff);
    wr(7'h1a, 8'hf6);
    rdc(7'h1b, 16'h1ff6, "bias x");
    // y and z offsets written, read back, then cleared again
    for (a = 7'h1c; a < 7'h20; a = a + 7'h02)
    begin
      wr(a + 7'h01, 8'h01);
      wr(a, 8'h23);
      rdc(a, 16'h0123, "bias yz");
      wr(a, 8'h00);
      wr(a + 7'h01, 8'h00);
    end
    for (k = 0; k < 3; k = k + 1)
    begin
      range_sel = 3'h4 >> k;
      push(12'h814);
      sample_valid = 1'b0;
      repeat (8) @(negedge clk_sys);
      burst;
      bcheck(1'b1, 1'b0, 2 - k, -10);
    end
    range_sel = 3'h4;
    fork
      burst;
      begin
        repeat (200) @(negedge clk_sys);
        for (i = 0; i < 8; i = i + 1)
          push(12'h7ac + i[11:0]);
        sample_valid = 1'b0;
        repeat (3) @(negedge clk_sys);
        chk("fifo full", 16'h0000, {15'h0000, sample_ready});
      end
    join
    chk("stalled", 16'h0814, bw[0]);
    k = 0;
    while (sample_ready !== 1'b1 && k < 100)
    begin
      @(negedge clk_sys);
      k = k + 1;
    end
    chk("drained", 16'h0001, {15'h0000, sample_ready});
    repeat (20) @(negedge clk_sys);
    burst;
    bcheck(1'b1, 1'b0, 2, -10);
    complete_run;
  end
endmodule // tb_top
